// ---- oversampling_consts.vh ----
`ifndef OVERSAMPLING_CONSTS_VH
`define OVERSAMPLING_CONSTS_VH
`define WORD_W 16
`define FACTOR_W 7
`define FACTOR_MAX 7'h64
`define FACTOR_RST 7'h01
`define CLK_PERIOD_NS 32'h0000_0064
`define MIN_SAMPLE_NS 32'h0000_2710
`define TIME_W_FULL 64
`define TIME_W_VOLT 32
`define PTR_W 7
`define BANK_DEPTH 100
`endif

// ---- sample_fifo.v ----
`default_nettype none
module sample_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire sys_clk,
    input wire rst_n,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0] wr_q;
    reg [AW-1:0] rd_q;
    reg [AW:0] cnt_q;
    wire push;
    wire pop;

    // Honest flags from the fill count
    assign in_ready = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[rd_q];

    // Pointers wrap on depth, so depth need not be a power of two
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                mem_q[wr_q] <= in_data;
                wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                    wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                    rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule // sample_fifo
`default_nettype wire

// ---- dc_time_counter.v ----
`include "oversampling_consts.vh"
`default_nettype none
module dc_time_counter #(
    parameter TIME_W = `TIME_W_FULL
) (
    input wire sys_clk,
    input wire rst_n,
    input wire time_load,
    input wire [TIME_W-1:0] time_load_value,
    input wire signed [15:0] time_adjust_ns,
    input wire time_adjust_valid,
    output reg [TIME_W-1:0] local_time_q
);
    reg [TIME_W-1:0] local_time_d;
    wire [TIME_W-1:0] step;

    // Nanoseconds elapsed per clock; zero means start of 2000
    assign step = `CLK_PERIOD_NS;

    // Master load wins, then drift correction, else free count
    always @* begin
        local_time_d = local_time_q + step;
        if (time_load) begin
            local_time_d = time_load_value;
        end else if (time_adjust_valid) begin
            local_time_d = local_time_q + step +
                {{(TIME_W-16){time_adjust_ns[15]}}, time_adjust_ns};
        end
    end

    // Narrow form simply wraps, no high word kept
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            local_time_q <= {TIME_W{1'b0}};
        end else begin
            local_time_q <= local_time_d;
        end
    end
endmodule // dc_time_counter
`default_nettype wire

// ---- oversampling_dac_sequencer.v ----
`include "oversampling_consts.vh"
`default_nettype none
module oversampling_dac_sequencer #(
    parameter VOLTAGE_VARIANT = 1,
    parameter FIFO_DEPTH = 8,
    parameter FIFO_AW = 3,
    parameter DEPTH = `BANK_DEPTH,
    parameter TIME_W = `TIME_W_VOLT,
    parameter CYCLE_NS = 32'd1000000
) (
    input wire sys_clk,
    input wire rst_n,
    input wire [`FACTOR_W-1:0] factor,
    input wire time_load,
    input wire [TIME_W-1:0] time_load_value,
    input wire signed [15:0] time_adjust_ns,
    input wire time_adjust_valid,
    output wire [TIME_W-1:0] local_time,
    input wire pd_valid,
    output wire pd_ready,
    input wire [2*`WORD_W-1:0] pd_data,
    input wire pd_last,
    output reg cycle_strobe_q,
    output reg sample_strobe_q,
    output reg [`WORD_W-1:0] dac_ch1_q,
    output reg [`WORD_W-1:0] dac_ch2_q,
    output reg dac_sign_ch1_q,
    output reg dac_sign_ch2_q,
    output reg dac_sync_q,
    output reg config_error_q
);
    // Two banks: one filled from the bus, one played out
    reg [2*`WORD_W-1:0] bank0_q [0:DEPTH-1];
    reg [2*`WORD_W-1:0] bank1_q [0:DEPTH-1];
    reg fill_bank_q;
    reg [`PTR_W-1:0] fill_ptr_q;
    reg fill_done_q;
    reg [`PTR_W-1:0] fill_len_q;
    reg [`PTR_W-1:0] play_len_q;
    reg play_ready_q;
    reg [`PTR_W-1:0] play_ptr_q;
    reg [`FACTOR_W-1:0] factor_q;
    reg [31:0] cyc_cnt_q;
    reg [31:0] smp_cnt_q;
    reg [31:0] smp_period_q;
    wire [31:0] smp_period_d;
    wire [31:0] smp_rem_d;
    wire [TIME_W-1:0] time_now;
    wire f_valid;
    wire f_ready;
    wire [2*`WORD_W:0] f_data;
    wire [2*`WORD_W-1:0] play_word;
    wire [31:0] divisor;
    wire [`PTR_W-1:0] play_idx;
    wire cyc_hit;
    wire smp_hit;
    wire factor_ok;

    dc_time_counter #(
        .TIME_W(TIME_W)
    ) u_time (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .time_load(time_load),
        .time_load_value(time_load_value),
        .time_adjust_ns(time_adjust_ns),
        .time_adjust_valid(time_adjust_valid),
        .local_time_q(time_now)
    );
    assign local_time = time_now;

    // Incoming words queue here; fill side drains until a packet is complete
    sample_fifo #(
        .WIDTH(2*`WORD_W+1),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .in_valid(pd_valid),
        .in_ready(pd_ready),
        .in_data({pd_last, pd_data}),
        .out_valid(f_valid),
        .out_ready(f_ready),
        .out_data(f_data)
    );

    // Stall draining once a full packet waits for its strobe
    assign f_ready = !fill_done_q;

    // Sample period derived from cycle length, shared by channels
    // Zero factor divides by one; it is flagged as an error anyway
    assign divisor = (factor_q == 7'h00) ? 32'h0000_0001 :
        {25'h0000000, factor_q};
    assign smp_period_d = CYCLE_NS / divisor;
    assign smp_rem_d = CYCLE_NS % divisor;
    assign factor_ok = (factor_q != 7'h00) &&
        (factor_q <= `FACTOR_MAX) &&
        (smp_rem_d == 32'h0000_0000) &&
        (smp_period_d >= `MIN_SAMPLE_NS);

    // Strobes fire from the nanosecond count
    assign cyc_hit = (cyc_cnt_q + `CLK_PERIOD_NS >= CYCLE_NS);
    assign smp_hit = (smp_cnt_q + `CLK_PERIOD_NS >= smp_period_q);

    // Factor is only taken at a cycle boundary to keep spacing even
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            factor_q <= `FACTOR_RST;
            smp_period_q <= CYCLE_NS;
            config_error_q <= 1'b0;
        end else begin
            if (cyc_hit) begin
                factor_q <= factor;
            end
            smp_period_q <= smp_period_d;
            config_error_q <= !factor_ok;
        end
    end

    // Cycle and sample timers; sample timer realigns on cycle
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            cyc_cnt_q <= 32'h0000_0000;
            smp_cnt_q <= 32'h0000_0000;
            cycle_strobe_q <= 1'b0;
            sample_strobe_q <= 1'b0;
        end else begin
            cycle_strobe_q <= cyc_hit;
            sample_strobe_q <= cyc_hit || smp_hit;
            if (cyc_hit) begin
                cyc_cnt_q <= 32'h0000_0000;
                smp_cnt_q <= 32'h0000_0000;
            end else begin
                cyc_cnt_q <= cyc_cnt_q + `CLK_PERIOD_NS;
                if (smp_hit) begin
                    smp_cnt_q <= 32'h0000_0000;
                end else begin
                    smp_cnt_q <= smp_cnt_q + `CLK_PERIOD_NS;
                end
            end
        end
    end

    // Fill side: words enter the idle bank up to the packet end
    always @(posedge sys_clk) begin
        if (f_valid && f_ready) begin
            if (fill_bank_q) begin
                bank1_q[fill_ptr_q] <= f_data[2*`WORD_W-1:0];
            end else begin
                bank0_q[fill_ptr_q] <= f_data[2*`WORD_W-1:0];
            end
        end
    end

    // Packet bookkeeping; a packet is cut at depth and later words wait to start the next one
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            fill_bank_q <= 1'b0;
            fill_ptr_q <= 7'h00;
            fill_done_q <= 1'b0;
            fill_len_q <= 7'h00;
            play_len_q <= 7'h00;
            play_ready_q <= 1'b0;
        end else begin
            // No new packet: stop playing so the last word holds
            if (cyc_hit) begin
                play_ready_q <= fill_done_q;
            end
            if (cyc_hit && fill_done_q) begin
                // Swap one clock ahead so the strobe plays word zero
                fill_bank_q <= !fill_bank_q;
                play_len_q <= fill_len_q;
                fill_ptr_q <= 7'h00;
                fill_done_q <= 1'b0;
            end else if (f_valid && f_ready) begin
                if (f_data[2*`WORD_W] ||
                        fill_ptr_q == DEPTH[`PTR_W-1:0] - 7'h01) begin
                    fill_done_q <= 1'b1;
                    fill_len_q <= fill_ptr_q + 7'h01;
                end else begin
                    fill_ptr_q <= fill_ptr_q + 7'h01;
                end
            end
        end
    end

    // Played bank is the one not being filled
    // Strobe at the cycle boundary plays the first word
    assign play_idx = cycle_strobe_q ? 7'h00 : play_ptr_q;
    assign play_word = fill_bank_q ? bank0_q[play_idx] :
        bank1_q[play_idx];

    // One word per channel per sample strobe; both latched at once
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            play_ptr_q <= 7'h00;
            dac_ch1_q <= 16'h0000;
            dac_ch2_q <= 16'h0000;
            dac_sign_ch1_q <= 1'b0;
            dac_sign_ch2_q <= 1'b0;
            dac_sync_q <= 1'b0;
        end else begin
            dac_sync_q <= 1'b0;
            if (sample_strobe_q && play_ready_q &&
                    play_idx < play_len_q) begin
                dac_ch1_q <= play_word[`WORD_W-1:0];
                dac_ch2_q <= play_word[2*`WORD_W-1:`WORD_W];
                // Current form carries a sign; voltage form does not
                dac_sign_ch1_q <= (VOLTAGE_VARIANT == 0) &&
                    play_word[`WORD_W-1];
                dac_sign_ch2_q <= (VOLTAGE_VARIANT == 0) &&
                    play_word[2*`WORD_W-1];
                dac_sync_q <= 1'b1;
                play_ptr_q <= play_idx + 7'h01;
            end else if (cycle_strobe_q) begin
                play_ptr_q <= 7'h00;
            end
            // Otherwise outputs hold the last word
        end
    end
endmodule // oversampling_dac_sequencer
`default_nettype wire

// ---- seq_checker_asserts.sv ----
`include "oversampling_consts.vh"
`default_nettype none
module seq_checker #(
    parameter int VV = 1,
    parameter int CYCLE_NS = 1000000
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [`FACTOR_W-1:0] factor,
    input wire logic time_load,
    input wire logic time_adjust_valid,
    input wire logic [31:0] local_time,
    input wire logic pd_valid,
    input wire logic pd_ready,
    input wire logic cycle_strobe_q,
    input wire logic sample_strobe_q,
    input wire logic [15:0] dac_ch1_q,
    input wire logic [15:0] dac_ch2_q,
    input wire logic dac_sign_ch1_q,
    input wire logic dac_sign_ch2_q,
    input wire logic dac_sync_q,
    input wire logic config_error_q
);
    localparam int CYC = CYCLE_NS / 100;
    logic [15:0] ccnt_q, scnt_q;
    logic cseen_q, sseen_q;
    logic [6:0] f1_q, f2_q;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // Spacing counters; factor kept over two cycles so a change is skipped
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            {ccnt_q, scnt_q, cseen_q, sseen_q, f1_q, f2_q} <= '0;
        end else begin
            ccnt_q <= cycle_strobe_q ? 16'h0 : ccnt_q + 16'h1;
            scnt_q <= sample_strobe_q ? 16'h0 : scnt_q + 16'h1;
            cseen_q <= cseen_q | cycle_strobe_q;
            sseen_q <= sseen_q | sample_strobe_q;
            if (cycle_strobe_q) begin
                f1_q <= factor;
                f2_q <= f1_q;
            end
        end
    end

    a_sync_after_sample: assert property (
        dac_sync_q |-> $past(sample_strobe_q)) else $error("sync no strobe");
    a_dac_hold_steady: assert property (
        !dac_sync_q |-> $stable(dac_ch1_q) && $stable(dac_ch2_q))
        else $error("dac moved");
    a_sync_one_pulse: assert property (
        dac_sync_q |=> !dac_sync_q) else $error("sync too long");
    a_cycle_has_sample: assert property (
        cycle_strobe_q && !config_error_q |-> sample_strobe_q)
        else $error("cycle without sample");
    a_cycle_period_exact: assert property (
        cycle_strobe_q && cseen_q |-> int'(ccnt_q) == CYC - 1)
        else $error("cycle period");
    a_sample_period_exact: assert property (
        sample_strobe_q && sseen_q && !config_error_q && f1_q == f2_q
        && f1_q != 0 |-> int'(scnt_q) == CYCLE_NS / int'(f1_q) / 100 - 1)
        else $error("sample period");
    a_sign_bit_rule: assert property (
        (VV != 0) ? (!dac_sign_ch1_q && !dac_sign_ch2_q)
        : (dac_sign_ch1_q == dac_ch1_q[15] && dac_sign_ch2_q == dac_ch2_q[15]))
        else $error("sign bit");
    a_time_ns_step: assert property (
        $past(rst_n) && !$past(time_load) && !$past(time_adjust_valid)
        |-> local_time == $past(local_time) + 32'd100)
        else $error("time step");
    cover property (dac_sync_q);
    cover property (config_error_q);
    cover property (pd_valid && !pd_ready);
endmodule // seq_checker

bind oversampling_dac_sequencer seq_checker #(.VV(VOLTAGE_VARIANT),
    .CYCLE_NS(CYCLE_NS)) seq_checker_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .factor(factor), .time_load(time_load), .local_time(local_time),
    .time_adjust_valid(time_adjust_valid), .pd_valid(pd_valid),
    .pd_ready(pd_ready), .cycle_strobe_q(cycle_strobe_q),
    .sample_strobe_q(sample_strobe_q), .dac_ch1_q(dac_ch1_q),
    .dac_ch2_q(dac_ch2_q), .dac_sign_ch1_q(dac_sign_ch1_q),
    .dac_sign_ch2_q(dac_sign_ch2_q), .dac_sync_q(dac_sync_q),
    .config_error_q(config_error_q));
`default_nettype wire

// ---- pd_source.sv ----
`default_nettype none
module pd_source (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic pd_ready,
    input wire logic go,
    input wire logic [6:0] n,
    input wire logic [15:0] base,
    output logic pd_valid,
    output logic pd_last,
    output logic busy,
    output logic stalled,
    output logic [31:0] pd_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [6:0] k_q;
    logic [15:0] nxt;
    assign nxt = base + {9'h0, k_q} + 16'h1;

    // One packet of n words, ch2 = inverse of ch1; held until taken
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            {pd_valid, pd_last, busy, stalled, k_q} <= '0;
            pd_data <= 32'h0;
        end else if (go) begin
            {busy, pd_valid, stalled, k_q} <= {3'b110, 7'h0};
            pd_data <= {~base, base};
            pd_last <= (n == 7'h1);
        end else if (pd_valid) begin
            if (!pd_ready) begin
                stalled <= 1'b1;
            end else if (pd_last) begin
                // Released bus shows no stale word
                {pd_valid, busy, pd_last} <= 3'b000;
                pd_data <= ~pd_data;
            end else begin
                k_q <= k_q + 7'h1;
                pd_data <= {~nxt, nxt};
                pd_last <= (k_q + 7'h2 == n);
            end
        end
    end
endmodule // pd_source
`default_nettype wire

// ---- tb.sv ----
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
    err_total++; $display("CHECK FAILED t=%0t got=%h exp=%h", \
    $time, a, b); end end
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 0, rst_n = 0, time_load = 0, time_adjust_valid = 0;
    logic go = 0;
    logic [6:0] factor = 7'h02, n = 7'h02;
    logic [31:0] time_load_value = 32'h0, t0;
    logic signed [15:0] time_adjust_ns = 16'sh0;
    logic [15:0] base = 16'h0;
    wire [31:0] pd_data, local_time;
    wire [15:0] dac_ch1_q, dac_ch2_q;
    wire pd_valid, pd_ready, pd_last, busy, stalled, cycle_strobe_q;
    wire sample_strobe_q, dac_sign_ch1_q, dac_sign_ch2_q, dac_sync_q;
    wire config_error_q;
    int err_total = 0, samples_checked = 0;

    oversampling_dac_sequencer #(.CYCLE_NS(32'd20000))
        oversampling_dac_sequencer_i (.*);
    pd_source pd_source_i (.*);

    // 100 ns clock
    initial forever #50 sys_clk = ~sys_clk;

    task end_of_test;
        $display("checks=%0d errors=%0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Bounded wait: 0 for a cycle strobe, 1 for a converter update
    task wait_hi(input bit sel);
        int i;
        i = 0;
        do begin
            @(posedge sys_clk);
            #1;
            i++;
        end while ((sel ? dac_sync_q : cycle_strobe_q) !== 1'b1 && i < 400);
        `CHK(i < 400, 1'b1)
    endtask

    task send(input logic [15:0] b, input logic [6:0] cnt);
        @(posedge sys_clk) {base, n, go} <= {b, cnt, 1'b1};
        @(posedge sys_clk) go <= 1'b0;
    endtask

    task expect_word(input logic [15:0] w);
        wait_hi(1);
        `CHK({dac_ch2_q, dac_ch1_q}, {~w, w})
    endtask

    task t_packet;
        wait_hi(0);
        send(16'h1234, 7'h02);
        wait_hi(0);
        expect_word(16'h1234);
        expect_word(16'h1235);
        wait_hi(0);
        repeat (150) @(posedge sys_clk);
        #1;
        `CHK(dac_ch1_q, 16'h1235)
    endtask

    // Second packet fills the buffer while the first waits for its swap
    task t_fifo;
        wait_hi(0);
        send(16'ha000, 7'h02);
        repeat (6) @(posedge sys_clk);
        send(16'hb000, 7'h0c);
        repeat (20) @(posedge sys_clk);
        #1;
        `CHK({stalled, busy, pd_ready}, 3'b110)
        wait_hi(0);
        expect_word(16'ha000);
        expect_word(16'ha001);
        wait_hi(0);
        `CHK(busy, 1'b0)
        expect_word(16'hb000);
        expect_word(16'hb001);
    endtask

    task t_config;
        logic [6:0] bad [4] = '{7'h00, 7'h03, 7'h05, 7'h65};
        foreach (bad[j]) begin
            @(posedge sys_clk) factor <= bad[j];
            repeat (3) wait_hi(0);
            `CHK(config_error_q, 1'b1)
        end
        @(posedge sys_clk) factor <= 7'h02;
        repeat (3) wait_hi(0);
        `CHK(config_error_q, 1'b0)
    endtask

    // Load near the top of the 32-bit range, wrap, then a correction
    task t_time;
        wait_hi(0);
        @(posedge sys_clk) {time_load, time_load_value} <= {1'b1, 32'hffffff9c};
        @(posedge sys_clk) time_load <= 1'b0;
        @(posedge sys_clk);
        #1;
        `CHK(local_time, 32'h0)
        t0 = local_time;
        @(posedge sys_clk) {time_adjust_valid, time_adjust_ns} <= {1'b1, 16'sd50};
        @(posedge sys_clk) time_adjust_valid <= 1'b0;
        @(posedge sys_clk);
        #1;
        `CHK(local_time, t0 + 32'd350)
    endtask

    initial begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_packet;
        t_fifo;
        t_config;
        t_time;
        end_of_test;
    end

    // Run needs about 0.45 ms
    initial begin
        #3000000;
        err_total++;
        end_of_test;
    end
endmodule // tb
`default_nettype wire
